// file: design/graph_parser_pkg.sv
// Constants and carrier types for the graph drawing command parser.
// Assumes 7-bit characters arriving one per strobe from a receiver.
package graph_parser_pkg;

    localparam int char_width = 7;
    localparam int data_width = 10;
    localparam int part_width = 5;
    localparam logic [6:0] char_escape = 7'h1b;
    localparam logic [6:0] char_enter = 7'h31;
    localparam logic [6:0] char_leave = 7'h32;
    localparam logic [6:0] char_delete = 7'h7f;
    localparam logic [6:0] control_limit = 7'h20;
    localparam logic [1:0] data_tag = 2'h1;
    localparam int tag_msb = 6;
    localparam int tag_lsb = 5;

    // Command characters
    localparam logic [6:0] cmd_nop = 7'h40;
    localparam logic [6:0] cmd_status0 = 7'h41;
    localparam logic [6:0] cmd_graph0 = 7'h42;
    localparam logic [6:0] cmd_marker0 = 7'h43;
    localparam logic [6:0] cmd_line0 = 7'h44;
    localparam logic [6:0] cmd_set_x = 7'h48;
    localparam logic [6:0] cmd_status1 = 7'h49;
    localparam logic [6:0] cmd_graph1 = 7'h4a;
    localparam logic [6:0] cmd_marker1 = 7'h4b;
    localparam logic [6:0] cmd_line1 = 7'h4c;

    typedef enum logic [3:0] {
        op_status0 = 4'h0,
        op_graph0 = 4'h1,
        op_marker0 = 4'h2,
        op_line0 = 4'h3,
        op_set_x = 4'h4,
        op_status1 = 4'h5,
        op_graph1 = 4'h6,
        op_marker1 = 4'h7,
        op_line1 = 4'h8
    } op_type;

    typedef enum logic [3:0] {
        mode_normal = 4'h1,
        mode_escape = 4'h2,
        mode_graph = 4'h4,
        mode_graph_escape = 4'h8
    } mode_type;

    typedef struct packed {
        op_type op;
        logic [9:0] value;
    } command_type;

    typedef struct packed {
        logic valid;
        logic [6:0] code;
    } char_type;

endpackage : graph_parser_pkg

// file: design/graph_drawing_command_parser.sv
// Graph drawing mode character parser: mode switching, command decode, data assembly.
// Assumes characters from a receiver on sys_clk, one-cycle strobe per character.
//
// Contract
// (R01) Escape then code 061 enters graph drawing mode.
// (R02) Escape then 062 in graph mode leaves it, restoring prior mode.
// (R03) Ten command characters recognised; @ does nothing.
// (R04) B loads graph 0, J loads graph 1 from following data.
// (R05) A and I update display status controls from following data.
// (R06) C and K load or erase markers per following data.
// (R07) D and L load or erase lines per following data.
// (R08) H sets the X coordinate from its data value.
// (R09) Non-nop commands collect one or two data characters before acting.
// (R10) Data characters have top bits 0 then 1, codes 040-077.
// (R11) First data character is low five bits, second high five bits.
// (R12) Word is low part plus high part times octal 40.
// (R13) Single-character commands use the low five-bit value alone.
// (R14) Host sends low part first; reversed order gives wrong value.
// (R15) Other characters are checked for escape or control code.
// (R16) Other non-escape, non-control characters are discarded, mode kept.
// (R17) Every escape enters an intermediate state selecting the next function.
// (R18) Data without pending command is dropped; new command abandons partial data.
// (R19) Per-command table holds the needed data character count.
`timescale 1ns/1ns

module graph_drawing_command_parser #(
    parameter logic [8:0] two_char_mask = 9'h1ff
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire graph_parser_pkg::char_type rx_char,
    output logic graph_mode,
    output logic escape_pending,
    output logic escape_select,
    output logic [6:0] escape_code,
    output logic control_strobe,
    output logic [6:0] control_code,
    output logic alpha_char_strobe,
    output logic [6:0] alpha_char,
    output logic command_strobe,
    output graph_parser_pkg::command_type command,
    output logic discard_strobe
);

    ////////////////////////////////////////////////////////////////////////
    // Character classes

    function automatic logic is_data(input logic [6:0] code);
        return code[graph_parser_pkg::tag_msb:graph_parser_pkg::tag_lsb] == graph_parser_pkg::data_tag; // R10
    endfunction : is_data

    function automatic logic is_control(input logic [6:0] code);
        return (code < graph_parser_pkg::control_limit) || (code == graph_parser_pkg::char_delete);
    endfunction : is_control

    function automatic logic [graph_parser_pkg::part_width-1:0] data_part(input logic [6:0] code);
        return code[graph_parser_pkg::part_width-1:0]; // R10
    endfunction : data_part

    function automatic logic graph_level(input graph_parser_pkg::mode_type m);
        return (m == graph_parser_pkg::mode_graph) || (m == graph_parser_pkg::mode_graph_escape);
    endfunction : graph_level

    function automatic logic escape_level(input graph_parser_pkg::mode_type m);
        return (m == graph_parser_pkg::mode_escape) || (m == graph_parser_pkg::mode_graph_escape);
    endfunction : escape_level

    // Command table lookup
    function automatic logic lookup(input logic [6:0] code, output graph_parser_pkg::op_type op);
        op = graph_parser_pkg::op_status0;
        lookup = 1'b1;
        unique case (code) // R03
            graph_parser_pkg::cmd_status0: op = graph_parser_pkg::op_status0; // R05
            graph_parser_pkg::cmd_status1: op = graph_parser_pkg::op_status1; // R05
            graph_parser_pkg::cmd_graph0: op = graph_parser_pkg::op_graph0; // R04
            graph_parser_pkg::cmd_graph1: op = graph_parser_pkg::op_graph1; // R04
            graph_parser_pkg::cmd_marker0: op = graph_parser_pkg::op_marker0; // R06
            graph_parser_pkg::cmd_marker1: op = graph_parser_pkg::op_marker1; // R06
            graph_parser_pkg::cmd_line0: op = graph_parser_pkg::op_line0; // R07
            graph_parser_pkg::cmd_line1: op = graph_parser_pkg::op_line1; // R07
            graph_parser_pkg::cmd_set_x: op = graph_parser_pkg::op_set_x; // R08
            default: lookup = 1'b0;
        endcase
    endfunction : lookup

    ////////////////////////////////////////////////////////////////////////
    // State

    graph_parser_pkg::mode_type mode;
    graph_parser_pkg::mode_type next_mode;
    logic pending;
    logic need_two;
    logic have_low;
    logic [4:0] low_part;
    graph_parser_pkg::op_type pending_op;

    logic [6:0] code;
    logic is_cmd;
    logic is_nop;
    graph_parser_pkg::op_type decoded_op;
    logic in_graph;
    logic [9:0] word_value;
    logic [9:0] single_value;
    logic take_graph;
    logic take_data;
    logic take_control;
    logic take_stray;
    logic take_alpha;
    logic take_escape_select;

    always_comb begin
        code = rx_char.code;
        is_cmd = lookup(code, decoded_op);
        is_nop = code == graph_parser_pkg::cmd_nop; // R03
        in_graph = graph_level(mode);
        word_value = {data_part(code), low_part}; // R11 R12
        single_value = {{graph_parser_pkg::part_width{1'b0}}, data_part(code)}; // R13
    end

    always_comb begin
        take_graph = rx_char.valid && (mode == graph_parser_pkg::mode_graph);
        take_data = take_graph && !is_cmd && !is_nop && is_data(code); // R10
        take_control = take_graph && (code != graph_parser_pkg::char_escape) && is_control(code); // R15
        take_stray = take_graph && !is_cmd && !is_nop && !is_data(code) && !is_control(code); // R16
        take_alpha = rx_char.valid && (mode == graph_parser_pkg::mode_normal) && (code != graph_parser_pkg::char_escape);
        take_escape_select = rx_char.valid && escape_level(mode) && (code != graph_parser_pkg::char_escape); // R17
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode machine

    always_comb begin
        next_mode = mode;
        if (rx_char.valid) begin
            unique case (mode)
                graph_parser_pkg::mode_normal: begin
                    if (code == graph_parser_pkg::char_escape) begin
                        next_mode = graph_parser_pkg::mode_escape; // R17
                    end
                end
                graph_parser_pkg::mode_escape: begin
                    if (code == graph_parser_pkg::char_escape) begin
                        next_mode = graph_parser_pkg::mode_escape; // R17
                    end else if (code == graph_parser_pkg::char_enter) begin
                        next_mode = graph_parser_pkg::mode_graph; // R01
                    end else begin
                        next_mode = graph_parser_pkg::mode_normal;
                    end
                end
                graph_parser_pkg::mode_graph: begin
                    if (code == graph_parser_pkg::char_escape) begin
                        next_mode = graph_parser_pkg::mode_graph_escape; // R15 R17
                    end
                end
                graph_parser_pkg::mode_graph_escape: begin
                    if (code == graph_parser_pkg::char_escape) begin
                        next_mode = graph_parser_pkg::mode_graph_escape; // R17
                    end else if (code == graph_parser_pkg::char_leave) begin
                        next_mode = graph_parser_pkg::mode_normal; // R02
                    end else begin
                        next_mode = graph_parser_pkg::mode_graph;
                    end
                end
                default: next_mode = graph_parser_pkg::mode_normal;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode <= graph_parser_pkg::mode_normal;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            graph_mode <= 1'b0;
            escape_pending <= 1'b0;
        end else begin
            graph_mode <= graph_level(next_mode); // R01 R02
            escape_pending <= escape_level(next_mode); // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command and data collection

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pending <= 1'b0;
        end else if (take_graph && is_cmd) begin
            pending <= 1'b1; // R09
        end else if (take_graph && is_nop) begin
            pending <= 1'b0; // R18
        end else if (take_data && pending && (!need_two || have_low)) begin
            pending <= 1'b0; // R09
        end else if (!in_graph) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            have_low <= 1'b0;
            low_part <= '0;
        end else if (take_graph && (is_cmd || is_nop)) begin
            have_low <= 1'b0; // R18
        end else if (take_data && pending) begin
            if (need_two && !have_low) begin
                have_low <= 1'b1; // R11
                low_part <= data_part(code);
            end else begin
                have_low <= 1'b0;
            end
        end else if (!in_graph) begin
            have_low <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            need_two <= 1'b0;
            pending_op <= graph_parser_pkg::op_status0;
        end else if (take_graph && is_cmd) begin
            need_two <= two_char_mask[decoded_op]; // R19
            pending_op <= decoded_op; // R03
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            command_strobe <= 1'b0;
            command <= '0;
        end else begin
            command_strobe <= 1'b0;
            if (take_data && pending && (!need_two || have_low)) begin
                command_strobe <= 1'b1; // R09
                command.op <= pending_op; // R04 R05 R06 R07 R08
                command.value <= need_two ? word_value : single_value; // R11 R13
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            discard_strobe <= 1'b0;
        end else begin
            discard_strobe <= 1'b0;
            if (take_data && !pending) begin
                discard_strobe <= 1'b1; // R18
            end
            if (take_stray) begin
                discard_strobe <= 1'b1; // R16
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            control_strobe <= 1'b0;
            control_code <= '0;
        end else begin
            control_strobe <= 1'b0;
            if (take_control) begin
                control_strobe <= 1'b1; // R15
                control_code <= code;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alpha_char_strobe <= 1'b0;
            alpha_char <= '0;
        end else begin
            alpha_char_strobe <= 1'b0;
            if (take_alpha) begin
                alpha_char_strobe <= 1'b1; // R02
                alpha_char <= code;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            escape_select <= 1'b0;
            escape_code <= '0;
        end else begin
            escape_select <= 1'b0;
            if (take_escape_select) begin
                escape_select <= 1'b1; // R17
                escape_code <= code;
            end
        end
    end

endmodule : graph_drawing_command_parser

// file: verif/host_char_source.sv
// Host model: sends characters to the parser one strobe at a time.
// Assumes the parser takes a character at each sys_clk rising edge.
`timescale 1ns/1ns
module host_char_source (
    output graph_parser_pkg::char_type rx_char,
    input wire logic sys_clk
);
    initial rx_char = '0;
    // Offer one character, then release the line with a changed code
    task automatic send(input logic [6:0] c);
        @(posedge sys_clk);
        #1 rx_char = {1'b1, c};
        @(posedge sys_clk);
        #1 rx_char = {1'b0, ~c};
    endtask : send
endmodule : host_char_source

// file: verif/graph_drawing_command_parser_assertions.sv
// Checker for the graph drawing command parser.
// Assumes it is bound to the parser's top module.
`timescale 1ns/1ns
module parser_checker #(
    parameter logic [8:0] two_char_mask = 9'h1ff
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire graph_parser_pkg::char_type rx_char,
    input wire logic graph_mode,
    input wire logic escape_pending,
    input wire logic escape_select,
    input wire logic [6:0] escape_code,
    input wire logic alpha_char_strobe,
    input wire logic [6:0] alpha_char,
    input wire logic control_strobe,
    input wire logic [6:0] control_code,
    input wire logic command_strobe,
    input wire graph_parser_pkg::command_type command,
    input wire logic discard_strobe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Character taken in plain graph mode
    wire logic in_graph = rx_char.valid && graph_mode && !escape_pending;
    wire logic [6:0] c = rx_char.code;
    ////////////////////////////////////////////////////////////////
    a_enter_graph: assert property (rx_char.valid && escape_pending && !graph_mode && c == 7'h31 |=> graph_mode)
        else $error("graph mode not entered");
    a_leave_graph: assert property (rx_char.valid && escape_pending && graph_mode && c == 7'h32 |=> !graph_mode)
        else $error("graph mode not left");
    a_escape_state: assert property (rx_char.valid && c == 7'h1b |=> escape_pending)
        else $error("escape state missing");
    a_stray_dropped: assert property (in_graph && c inside {[7'h45:7'h47], [7'h4d:7'h7e]}
        |=> discard_strobe && graph_mode)
        else $error("stray character not dropped");
    a_control_seen: assert property (in_graph && (c < 7'h20 || c == 7'h7f) && c != 7'h1b
        |=> control_strobe && control_code == $past(c))
        else $error("control code not reported");
    a_nop_silent: assert property (in_graph && c == 7'h40 |=> !command_strobe && !discard_strobe)
        else $error("no-operation had an effect");
    a_data_cause: assert property (command_strobe |-> $past(rx_char.valid) && $past(c[6:5]) == 2'h1)
        else $error("command without data character");
    a_single_low: assert property (command_strobe && !two_char_mask[command.op]
        |-> command.value == {5'h00, $past(c[4:0])})
        else $error("single data value wrong");
    a_high_part: assert property (command_strobe && two_char_mask[command.op]
        |-> command.value[9:5] == $past(c[4:0]))
        else $error("high part wrong");
    a_escape_select: assert property (rx_char.valid && escape_pending && c != 7'h1b
        |=> escape_select && escape_code == $past(c))
        else $error("escape selector not reported");
    a_alpha_normal: assert property (rx_char.valid && !graph_mode && !escape_pending && c != 7'h1b
        |=> alpha_char_strobe && alpha_char == $past(c) && !command_strobe)
        else $error("normal mode character not passed on");
endmodule : parser_checker
bind graph_drawing_command_parser parser_checker #(.two_char_mask(two_char_mask)) checker_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .rx_char(rx_char),
    .graph_mode(graph_mode),
    .escape_pending(escape_pending),
    .escape_select(escape_select),
    .escape_code(escape_code),
    .alpha_char_strobe(alpha_char_strobe),
    .alpha_char(alpha_char),
    .control_strobe(control_strobe),
    .control_code(control_code),
    .command_strobe(command_strobe),
    .command(command),
    .discard_strobe(discard_strobe)
);

// file: verif/graph_drawing_command_parser_tb.sv
// Testbench for the graph drawing command parser.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
module graph_drawing_command_parser_tb;
    logic sys_clk;
    logic srst;
    int mismatches = 0;
    int n_compared = 0;
    graph_parser_pkg::char_type rx_char;
    logic graph_mode;
    logic escape_pending;
    logic escape_select;
    logic control_strobe;
    logic alpha_char_strobe;
    logic command_strobe;
    logic discard_strobe;
    logic [6:0] escape_code;
    logic [6:0] control_code;
    logic [6:0] alpha_char;
    graph_parser_pkg::command_type command;
    always #50 sys_clk = ~sys_clk;
    host_char_source host (.rx_char(rx_char), .sys_clk(sys_clk));
    // Status commands take one data character
    graph_drawing_command_parser #(.two_char_mask(9'h1de)) dut (
        .sys_clk(sys_clk),
        .srst(srst),
        .rx_char(rx_char),
        .graph_mode(graph_mode),
        .escape_pending(escape_pending),
        .escape_select(escape_select),
        .escape_code(escape_code),
        .control_strobe(control_strobe),
        .control_code(control_code),
        .alpha_char_strobe(alpha_char_strobe),
        .alpha_char(alpha_char),
        .command_strobe(command_strobe),
        .command(command),
        .discard_strobe(discard_strobe)
    );
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    task automatic chk_cmd(input graph_parser_pkg::op_type op, input logic [9:0] v);
        chk(command_strobe === 1'b1 && command.op === op && command.value === v, "command");
    endtask : chk_cmd
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    task automatic t_enter;
        host.send(7'h1b);
        chk(escape_pending === 1'b1, "escape state");
        host.send(7'h31);
        chk(graph_mode === 1'b1 && escape_select === 1'b1 && escape_code === 7'h31, "enter");
        $display("test enter done");
    endtask : t_enter
    task automatic t_commands;
        logic [6:0] cmds [9] = '{7'h42, 7'h4a, 7'h43, 7'h4b, 7'h44, 7'h4c, 7'h48, 7'h41, 7'h49};
        graph_parser_pkg::op_type ops [9] = '{graph_parser_pkg::op_graph0, graph_parser_pkg::op_graph1,
            graph_parser_pkg::op_marker0, graph_parser_pkg::op_marker1, graph_parser_pkg::op_line0,
            graph_parser_pkg::op_line1, graph_parser_pkg::op_set_x, graph_parser_pkg::op_status0,
            graph_parser_pkg::op_status1};
        host.send(7'h48);
        host.send(7'h26);
        host.send(7'h23);
        chk_cmd(graph_parser_pkg::op_set_x, 10'h066);
        for (int i = 0; i < 9; i++) begin
            host.send(cmds[i]);
            host.send(7'h3f);
            if (i < 7) begin
                host.send(7'h20);
                chk_cmd(ops[i], 10'h01f);
            end else begin
                chk_cmd(ops[i], 10'h01f);
            end
        end
        host.send(7'h48);
        host.send(7'h23);
        host.send(7'h26);
        chk_cmd(graph_parser_pkg::op_set_x, 10'h0c3);
        $display("test commands done");
    endtask : t_commands
    task automatic t_filter;
        host.send(7'h40);
        host.send(7'h25);
        chk(discard_strobe === 1'b1 && command_strobe === 1'b0, "data after nop");
        host.send(7'h58);
        chk(discard_strobe === 1'b1 && graph_mode === 1'b1, "stray");
        host.send(7'h0d);
        chk(control_strobe === 1'b1 && control_code === 7'h0d, "control");
        host.send(7'h42);
        host.send(7'h21);
        host.send(7'h4a);
        host.send(7'h3e);
        host.send(7'h3f);
        chk_cmd(graph_parser_pkg::op_graph1, 10'h3fe);
        host.send(7'h24);
        chk(discard_strobe === 1'b1, "data after complete");
        $display("test filter done");
    endtask : t_filter
    task automatic t_leave;
        host.send(7'h1b);
        chk(graph_mode === 1'b1 && escape_pending === 1'b1, "graph escape");
        host.send(7'h32);
        chk(graph_mode === 1'b0, "leave");
        host.send(7'h41);
        chk(alpha_char_strobe === 1'b1 && alpha_char === 7'h41 && command_strobe === 1'b0, "normal");
        $display("test leave done");
    endtask : t_leave
    task automatic t_escape;
        host.send(7'h1b);
        host.send(7'h1b);
        chk(graph_mode === 1'b1 && escape_pending === 1'b1 && escape_select === 1'b0, "escape repeat");
        host.send(7'h41);
        chk(graph_mode === 1'b1 && escape_pending === 1'b0 && command_strobe === 1'b0, "back to graph");
        chk(escape_select === 1'b1 && escape_code === 7'h41, "graph escape select");
        $display("test escape done");
    endtask : t_escape
    task automatic t_reset;
        host.send(7'h1b);
        host.send(7'h5a);
        chk(graph_mode === 1'b0 && escape_pending === 1'b0, "normal escape return");
        chk(escape_select === 1'b1 && escape_code === 7'h5a, "normal escape select");
        host.send(7'h1b);
        host.send(7'h31);
        host.send(7'h48);
        host.send(7'h21);
        @(posedge sys_clk);
        #1 srst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 srst = 1'b0;
        chk(graph_mode === 1'b0 && escape_pending === 1'b0 && command_strobe === 1'b0, "reset");
        host.send(7'h23);
        chk(alpha_char_strobe === 1'b1 && alpha_char === 7'h23 && command_strobe === 1'b0, "after reset");
        $display("test reset done");
    endtask : t_reset
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        srst = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 srst = 1'b0;
        t_enter();
        t_commands();
        t_filter();
        t_escape();
        t_leave();
        t_reset();
        end_of_test();
    end
    initial begin
        repeat (1000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end
endmodule : graph_drawing_command_parser_tb
